// [ccb_pkg.sv]
/*
  Shared constants and carrier types for the charger control register bank.
  Assumes a single 250 MHz system clock; all times are turned into cycles.
*/
package ccb_pkg;

  // Clock period in nanoseconds
  localparam int CLK_PERIOD_NS = 4;

  // Command codes of the two configuration words
  localparam logic [7:0] CMD_CTRL_A = 8'h3C;
  localparam logic [7:0] CMD_CTRL_B = 8'h3D;

  // Reset values
  localparam logic [15:0] CTRL_A_RESET = 16'h0000;
  localparam logic [15:0] CTRL_B_RESET = 16'h0000;

  // First control word field positions
  localparam int A_FREQ_LSB = 7;
  localparam int A_TURBO_DIS = 6;
  localparam int A_MON_DIS = 5;
  localparam int A_MON_SEL = 4;
  localparam int A_SYSTEM_POWER_MONITOR_EN = 3;
  localparam int A_RAIL_DIS = 2;
  localparam int A_LOWRAIL_LSB = 0;

  // Second control word field positions
  localparam int B_TRICKLE_LSB = 14;
  localparam int B_OTG_FAST = 13;
  localparam int B_TWO_LEVEL = 12;
  localparam int B_GATE_FAST = 11;
  localparam int B_DEB_LSB = 9;
  localparam int B_DUR_LSB = 6;
  localparam int B_OTG_GATE_OFF = 5;
  localparam int B_CMP_REF_HI = 4;
  localparam int B_CMP_DIS = 3;
  localparam int B_CMP_INV = 2;
  localparam int B_GOCP_DIS = 1;
  localparam int B_SYSTEM_POWER_MONITOR_GAIN_LO = 0;

  // Low-rail threshold code forced for single-cell packs (2.4 V)
  localparam logic [2:0] LOWRAIL_1CELL = 3'h4;

  // Times in nanoseconds, as printed
  localparam int T_1300MS_NS = 1300000000;
  localparam int T_150MS_NS = 150000000;
  localparam int T_20MS_NS = 20000000;
  localparam int T_15MS_NS = 15000000;
  localparam int T_10MS_NS = 10000000;
  localparam int T_5MS_NS = 5000000;
  localparam int T_1MS_NS = 1000000;
  localparam int T_500US_NS = 500000;
  localparam int T_100US_NS = 100000;
  localparam int T_10US_NS = 10000;
  localparam int T_0S_NS = 0;

  // Least time to cycles, rounded up, never below one cycle
  function automatic int ccb_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Fixed low-rail debounce count
  localparam int LOWRAIL_DEB_CYC = ccb_cycles(T_10US_NS);

  // Decoded configuration towards the analog side
  typedef struct packed {
    logic       freq_override;
    logic [2:0] freq_code;
    logic       turbo_en;
    logic       monitor_en;
    logic       monitor_sel_battery_discharge_monitor;
    logic       system_power_monitor_en;
    logic       converter_switch_en;
    logic       battery_switch_gate_force_on;
    logic [2:0] low_rail_thr_code;
    logic [1:0] trickle_code;
    logic       two_level_en;
    logic       cmp_ref_hi;
    logic       cmp_en;
    logic       gocp_en;
    logic       system_power_monitor_gain_low;
  } ccb_cfg_s;

  // Block state shown to the system
  typedef struct packed {
    logic otg_active;
    logic adapter_gate_on;
    logic throttle_active;
    logic ac_qualified;
    logic dc_qualified;
    logic lr_qualified;
    logic first_insert_pending;
  } ccb_status_s;

endpackage

// [ccb_qual_timer.sv]
/*
  Qualification timer: reports that a condition has held for a count.
  Assumes cond_i and limit_i are synchronous to sys_clk_i.
*/
`timescale 1ns/1ns
module ccb_qual_timer #(
  parameter int CW = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic cond_i,
  input wire logic [CW-1:0] limit_i,
  output logic done_o
);

  logic [CW-1:0] cnt_reg; // Cycles the condition has held
  logic [CW-1:0] lim_reg; // Limit captured at interval start
  logic run_reg; // Interval in progress
  logic [CW-1:0] cnt_next;

  // Next count value
  assign cnt_next = CW'(cnt_reg + 1'b1);

  // Count while the condition holds, restart when it drops
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
      lim_reg <= '0;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!cond_i) begin
        // Condition gone: abandon interval
        cnt_reg <= '0;
        run_reg <= 1'b0;
        done_o <= 1'b0;
      end else if (!run_reg) begin
        // New interval keeps the setting seen now
        run_reg <= 1'b1;
        lim_reg <= limit_i;
        cnt_reg <= CW'(1);
        done_o <= (limit_i <= CW'(1));
      end else if (!done_o) begin
        // Running on the captured limit
        cnt_reg <= cnt_next;
        done_o <= (cnt_next >= lim_reg);
      end
    end
  end

endmodule

// [ccb_bank.sv]
/*
  Charger control register bank: two configuration words written by the
  host, decoded settings, throttle qualification, adapter gate and OTG
  enable delays. Assumes a word-level front end that delivers whole
  write-word and read-word commands, and analog comparators whose results
  arrive as levels synchronous to sys_clk_i.
*/
// Behaviour
// - Frequency code 000 keeps pin-set, else override
// - Turbo bit low enables battery gate turbo
// - Adapter present forces monitors on, bit ignored
// - Monitor select: zero adapter, one discharge
// - System power monitor enabled when bit set
// - Rail bit stops switching, holds battery gate
// - Low-rail threshold codes 6.0 to 6.9 volts
// - Single cell fixes low-rail threshold 2.4V
// - Trickle code selects 256,128,64,512 mA
// - OTG enable debounce 1.3s or 150ms
// - Two-level adapter limit enabled when set
// - Adapter gate delay 1.3s or 150ms
// - Insertions 150ms until first gate turn-off after reset
// - Adapter/discharge throttle debounce by code
// - Low-rail throttle fixed 10us debounce
// - Throttle minimum hold time by code
// - OTG mode: gate on unless bit set
// - Comparator reference 1.2V or 2V
// - Comparator enabled when bit is zero
// - Comparator output polarity by bit
// - Gross overcurrent protection enabled when zero
// - Power monitor gain 1.44 or 0.36
`timescale 1ns/1ns
module ccb_bank
  import ccb_pkg::*;
#(
  parameter int CW = 32,
  // OTG debounce in cycles: index 1 short, index 0 long
  parameter logic [1:0][31:0] OTG_CYC = {
    32'(ccb_cycles(T_150MS_NS)), 32'(ccb_cycles(T_1300MS_NS))},
  // Adapter gate delay in cycles: index 1 short, index 0 long
  parameter logic [1:0][31:0] GATE_CYC = {
    32'(ccb_cycles(T_150MS_NS)), 32'(ccb_cycles(T_1300MS_NS))},
  // Throttle debounce in cycles, indexed by code
  parameter logic [3:0][31:0] DEB_CYC = {
    32'(ccb_cycles(T_1MS_NS)), 32'(ccb_cycles(T_500US_NS)),
    32'(ccb_cycles(T_100US_NS)), 32'(ccb_cycles(T_10US_NS))},
  // Throttle minimum hold in cycles, indexed by code
  parameter logic [7:0][31:0] DUR_CYC = {
    32'(ccb_cycles(T_0S_NS)), 32'(ccb_cycles(T_100US_NS)),
    32'(ccb_cycles(T_500US_NS)), 32'(ccb_cycles(T_1MS_NS)),
    32'(ccb_cycles(T_5MS_NS)), 32'(ccb_cycles(T_15MS_NS)),
    32'(ccb_cycles(T_20MS_NS)), 32'(ccb_cycles(T_10MS_NS))}
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic wr_valid_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o,
  output logic ack_o,
  output logic nack_o,
  input wire logic adapter_present_i,
  input wire logic single_cell_i,
  input wire logic otg_request_i,
  input wire logic adapter_current_over_i,
  input wire logic battery_discharge_over_i,
  input wire logic low_rail_under_i,
  input wire logic comparator_above_i,
  input wire logic throttle_pin_i,
  output logic throttle_pin_o,
  output logic throttle_pin_oe_o,
  output logic throttle_pin_level_o,
  output logic comparator_output_o,
  output ccb_cfg_s cfg_o,
  output ccb_status_s status_o
);

  logic [15:0] ctrl_a_reg; // First control word
  logic [15:0] ctrl_b_reg; // Second control word
  logic throttle_reg; // Throttle asserted
  logic gate_on_reg; // Adapter switch gate drive
  logic first_reg; // No gate turn-off seen since reset
  logic cmp_reg; // Comparator output drive
  logic pin_reg; // Sampled throttle pin level
  logic ac_q, dc_q, lr_q, any_q; // Qualified throttle sources
  logic hold_done; // Minimum hold elapsed
  logic gate_q; // Adapter insertion qualified
  logic otg_q; // OTG request qualified
  logic gate_next; // Next gate drive
  logic [CW-1:0] deb_lim, dur_lim, gate_lim, otg_lim; // Timer limits

  // Host command port: write-word and read-word by command code
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ctrl_a_reg <= CTRL_A_RESET;
      ctrl_b_reg <= CTRL_B_RESET;
      rd_data_o <= 16'h0000;
      ack_o <= 1'b0;
      nack_o <= 1'b0;
    end else if (clk_en_i) begin
      ack_o <= 1'b0;
      nack_o <= 1'b0;
      if (wr_valid_i || rd_valid_i) begin
        unique case (cmd_code_i)
          CMD_CTRL_A: begin
            // Word lands whole on the first control word
            if (wr_valid_i) ctrl_a_reg <= wr_data_i;
            rd_data_o <= wr_valid_i ? rd_data_o : ctrl_a_reg;
            ack_o <= 1'b1;
          end
          CMD_CTRL_B: begin
            // Word lands whole on the second control word
            if (wr_valid_i) ctrl_b_reg <= wr_data_i;
            rd_data_o <= wr_valid_i ? rd_data_o : ctrl_b_reg;
            ack_o <= 1'b1;
          end
          default: begin
            // Unknown code: refused, nothing stored
            nack_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // Decoded settings of the first word
  always_comb begin
    cfg_o.freq_code = ctrl_a_reg[A_FREQ_LSB +: 3];
    cfg_o.freq_override = (ctrl_a_reg[A_FREQ_LSB +: 3] != 3'h0);
    cfg_o.turbo_en = !ctrl_a_reg[A_TURBO_DIS];
    cfg_o.monitor_en = adapter_present_i || !ctrl_a_reg[A_MON_DIS];
    cfg_o.monitor_sel_battery_discharge_monitor = ctrl_a_reg[A_MON_SEL];
    cfg_o.system_power_monitor_en = ctrl_a_reg[A_SYSTEM_POWER_MONITOR_EN];
    cfg_o.converter_switch_en = !ctrl_a_reg[A_RAIL_DIS];
    cfg_o.battery_switch_gate_force_on = ctrl_a_reg[A_RAIL_DIS];
    // Single cell overrides the selectable threshold
    if (single_cell_i) begin
      cfg_o.low_rail_thr_code = LOWRAIL_1CELL;
    end else begin
      cfg_o.low_rail_thr_code = {1'b0, ctrl_a_reg[A_LOWRAIL_LSB +: 2]};
    end
    // Decoded settings of the second word
    cfg_o.trickle_code = ctrl_b_reg[B_TRICKLE_LSB +: 2];
    cfg_o.two_level_en = ctrl_b_reg[B_TWO_LEVEL];
    cfg_o.cmp_ref_hi = ctrl_b_reg[B_CMP_REF_HI];
    cfg_o.cmp_en = !ctrl_b_reg[B_CMP_DIS];
    cfg_o.gocp_en = !ctrl_b_reg[B_GOCP_DIS];
    cfg_o.system_power_monitor_gain_low = ctrl_b_reg[B_SYSTEM_POWER_MONITOR_GAIN_LO];
  end

  // Throttle debounce length by code
  always_comb begin
    unique case (ctrl_b_reg[B_DEB_LSB +: 2])
      2'h0: deb_lim = CW'(DEB_CYC[0]);
      2'h1: deb_lim = CW'(DEB_CYC[1]);
      2'h2: deb_lim = CW'(DEB_CYC[2]);
      2'h3: deb_lim = CW'(DEB_CYC[3]);
    endcase
  end

  // Throttle minimum hold by code
  always_comb begin
    unique case (ctrl_b_reg[B_DUR_LSB +: 3])
      3'h0: dur_lim = CW'(DUR_CYC[0]);
      3'h1: dur_lim = CW'(DUR_CYC[1]);
      3'h2: dur_lim = CW'(DUR_CYC[2]);
      3'h3: dur_lim = CW'(DUR_CYC[3]);
      3'h4: dur_lim = CW'(DUR_CYC[4]);
      3'h5: dur_lim = CW'(DUR_CYC[5]);
      3'h6: dur_lim = CW'(DUR_CYC[6]);
      3'h7: dur_lim = CW'(DUR_CYC[7]);
    endcase
  end

  // Gate delay: short on first insertion, else by bit
  assign gate_lim = (first_reg || ctrl_b_reg[B_GATE_FAST]) ?
    CW'(GATE_CYC[1]) : CW'(GATE_CYC[0]);
  // OTG enable debounce by bit
  assign otg_lim = ctrl_b_reg[B_OTG_FAST] ?
    CW'(OTG_CYC[1]) : CW'(OTG_CYC[0]);

  // Adapter current throttle qualification
  ccb_qual_timer #(.CW(CW)) u_ac_deb (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cond_i(adapter_current_over_i), .limit_i(deb_lim), .done_o(ac_q));
  // Battery discharge throttle qualification
  ccb_qual_timer #(.CW(CW)) u_dc_deb (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cond_i(battery_discharge_over_i), .limit_i(deb_lim), .done_o(dc_q));
  // Low-rail throttle, fixed debounce
  ccb_qual_timer #(.CW(CW)) u_lr_deb (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cond_i(low_rail_under_i), .limit_i(CW'(LOWRAIL_DEB_CYC)),
    .done_o(lr_q));
  // Minimum hold since throttle assertion
  ccb_qual_timer #(.CW(CW)) u_hold (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cond_i(throttle_reg), .limit_i(dur_lim), .done_o(hold_done));
  // Adapter insertion to gate turn-on
  ccb_qual_timer #(.CW(CW)) u_gate (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cond_i(adapter_present_i), .limit_i(gate_lim), .done_o(gate_q));
  // OTG enable command debounce
  ccb_qual_timer #(.CW(CW)) u_otg (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cond_i(otg_request_i), .limit_i(otg_lim), .done_o(otg_q));

  assign any_q = ac_q || dc_q || lr_q;

  // Throttle: set by any source, released after hold and clear
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      throttle_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (any_q) begin
        throttle_reg <= 1'b1;
      end else if (hold_done) begin
        throttle_reg <= 1'b0;
      end
    end
  end

  // Gate drive: OTG setting wins over insertion delay
  assign gate_next = otg_q ? !ctrl_b_reg[B_OTG_GATE_OFF] : gate_q;

  // Adapter gate drive and first-insertion memory
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      gate_on_reg <= 1'b0;
      first_reg <= 1'b1;
    end else if (clk_en_i) begin
      gate_on_reg <= gate_next;
      // First turn-off ends the forced short delay
      if (gate_on_reg && !gate_next) first_reg <= 1'b0;
    end
  end

  // Comparator output with polarity, low while disabled
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cmp_reg <= 1'b0;
      pin_reg <= 1'b1;
    end else if (clk_en_i) begin
      cmp_reg <= cfg_o.cmp_en &&
        (comparator_above_i ^ ctrl_b_reg[B_CMP_INV]);
      pin_reg <= throttle_pin_i;
    end
  end

  // Open-drain throttle pin pulls low while asserted
  assign throttle_pin_o = 1'b0;
  assign throttle_pin_oe_o = throttle_reg;
  assign throttle_pin_level_o = pin_reg;
  assign comparator_output_o = cmp_reg;

  // Status outward
  assign status_o.otg_active = otg_q;
  assign status_o.adapter_gate_on = gate_on_reg;
  assign status_o.throttle_active = throttle_reg;
  assign status_o.ac_qualified = ac_q;
  assign status_o.dc_qualified = dc_q;
  assign status_o.lr_qualified = lr_q;
  assign status_o.first_insert_pending = first_reg;

  // Enabled cycles the low-rail condition has held, for the checks
  logic [CW-1:0] lr_run_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      lr_run_reg <= '0;
    end else if (clk_en_i) begin
      lr_run_reg <= low_rail_under_i ? CW'(lr_run_reg + 1'b1) : '0;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_write_a;
    clk_en_i && wr_valid_i && cmd_code_i == CMD_CTRL_A;
  endsequence
  sequence s_lr_held;
    clk_en_i && low_rail_under_i;
  endsequence

  AST_WRITE_A: assert property (s_write_a |=>
    ctrl_a_reg == $past(wr_data_i) && ack_o)
    else $error("first control word not written");
  AST_FREQ: assert property (cfg_o.freq_override ==
    (ctrl_a_reg[9:7] != 3'h0)) else $error("frequency override wrong");
  AST_MON: assert property (adapter_present_i |-> cfg_o.monitor_en)
    else $error("monitors not forced on with adapter");
  AST_RAIL: assert property (ctrl_a_reg[2] |->
    !cfg_o.converter_switch_en && cfg_o.battery_switch_gate_force_on)
    else $error("rail disable not honoured");
  AST_LOWRAIL: assert property (single_cell_i |->
    cfg_o.low_rail_thr_code == LOWRAIL_1CELL)
    else $error("single cell threshold not fixed");
  AST_LR_DEB: assert property (s_lr_held ##1 $rose(lr_q) |->
    lr_run_reg >= CW'(LOWRAIL_DEB_CYC))
    else $error("low rail qualified early");
  AST_THR_SET: assert property (clk_en_i && any_q |=> throttle_reg)
    else $error("throttle not asserted");
  AST_THR_HOLD: assert property (clk_en_i && throttle_reg &&
    !hold_done |=> throttle_reg) else $error("throttle released early");
  AST_FIRST: assert property (first_reg |->
    gate_lim == CW'(GATE_CYC[1])) else $error("first delay not short");
  AST_OTG_GATE: assert property (clk_en_i && otg_q |=>
    gate_on_reg == !$past(ctrl_b_reg[5]))
    else $error("otg gate drive wrong");
  AST_CMP: assert property (clk_en_i && !ctrl_b_reg[3] &&
    comparator_above_i && !ctrl_b_reg[2] |=> comparator_output_o)
    else $error("comparator output not high");

endmodule

// [ccb_host_model.sv]
/*
  Host model: word-level command master standing for the bus engine.
  Assumes one clock; requests are launched just after rising edges.
*/
`timescale 1ns/1ns
module ccb_host_model (
  input wire logic sys_clk_i,
  input wire logic ack_i,
  input wire logic nack_i,
  input wire logic [15:0] rd_data_i,
  output logic wr_valid_o,
  output logic rd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] wr_data_o
);
  // Idle command lines at time zero
  initial begin
    wr_valid_o = 1'b0;
    rd_valid_o = 1'b0;
    cmd_code_o = 8'h00;
    wr_data_o = 16'h0000;
  end

  // One command: held for one taking edge, answer sampled 1 ns after that edge
  task automatic xfer(input logic wr, input logic [7:0] cmd,
    input logic [15:0] d, output logic ack, output logic nack,
    output logic [15:0] q);
    @(posedge sys_clk_i);
    wr_valid_o <= wr;
    rd_valid_o <= ~wr;
    cmd_code_o <= cmd;
    wr_data_o <= d;
    @(posedge sys_clk_i);
    wr_valid_o <= 1'b0;
    rd_valid_o <= 1'b0;
    // Released lines show the inverse, never the stale value
    cmd_code_o <= ~cmd;
    wr_data_o <= ~d;
    #1;
    ack = ack_i;
    nack = nack_i;
    q = rd_data_i;
  endtask
endmodule

// [ccb_bank_tb_top.sv]
/*
  Self-checking bench for the charger control register bank.
  Assumes shortened timer parameters and a pulled-up throttle pin.
*/
`timescale 1ns/1ns
module ccb_bank_tb_top import ccb_pkg::*;;
  logic sys_clk_i, reset_n_i, clk_en_i, wr_valid_i, rd_valid_i;
  logic [7:0] cmd_code_i;
  logic [15:0] wr_data_i, rd_data_o;
  logic ack_o, nack_o, adapter_present_i, single_cell_i, otg_request_i;
  logic adapter_current_over_i, battery_discharge_over_i;
  logic low_rail_under_i, comparator_above_i, throttle_pin_o;
  logic throttle_pin_oe_o, throttle_pin_level_o, comparator_output_o;
  wire logic throttle_pin_i;
  ccb_cfg_s cfg_o;
  ccb_status_s status_o;
  int n_mismatch = 0;
  int num_checks = 0;
  // Shortened timer counts: index 1 short, index 0 long
  localparam logic [1:0][31:0] LONG_SHORT = {32'h0000_000A, 32'h0000_0028};
  // Shortened debounce counts by code
  localparam logic [3:0][31:0] DEB = {32'h0000_0009, 32'h0000_0007,
    32'h0000_0005, 32'h0000_0003};
  // Shortened hold counts by code
  localparam logic [7:0][31:0] DUR = {32'h0000_0001, 32'h0000_0004,
    32'h0000_0006, 32'h0000_0008, 32'h0000_000F, 32'h0000_0019,
    32'h0000_001E, 32'h0000_0014};

  // Open-drain pin with pull-up
  assign throttle_pin_i = throttle_pin_oe_o ? throttle_pin_o : 1'b1;

  ccb_bank #(.OTG_CYC(LONG_SHORT), .GATE_CYC(LONG_SHORT), .DEB_CYC(DEB),
    .DUR_CYC(DUR)) DUT (.*);

  ccb_host_model HOST (.sys_clk_i(sys_clk_i), .ack_i(ack_o),
    .nack_i(nack_o), .rd_data_i(rd_data_o), .wr_valid_o(wr_valid_i),
    .rd_valid_o(rd_valid_i), .cmd_code_o(cmd_code_i),
    .wr_data_o(wr_data_i));

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Write a word, expect acceptance
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic a, k;
    logic [15:0] q;
    HOST.xfer(1'b1, c, d, a, k, q);
    chk("write answer", {a, k}, 32'h0000_0002);
  endtask

  // Read a word and compare
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic a, k;
    logic [15:0] q;
    HOST.xfer(1'b0, c, 16'h0000, a, k, q);
    chk("read word", {a, k, q}, {2'b10, e});
  endtask

  // Observed output by selector
  function automatic logic pick(input int s);
    case (s)
      0: return throttle_pin_oe_o;
      1: return status_o.adapter_gate_on;
      default: return status_o.otg_active;
    endcase
  endfunction

  // Bounded wait, counts edges until the selected output equals v
  task automatic meas(input int s, input logic v, input int mx,
    output int n);
    n = 0;
    while (pick(s) !== v) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (n > mx) begin
        n_mismatch++;
        $display("BAD wait %0d expected %b seen timeout", s, v);
        end_sim();
      end
    end
  endtask

  // Cycle count within a window
  task automatic rng(input string nm, input int n, input int lo,
    input int hi);
    chk(nm, 32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask

  // Run-time limit
  initial begin
    #400000;
    n_mismatch++;
    $display("BAD run time expected done seen timeout");
    end_sim();
  end

  // Main sequence
  initial begin
    ccb_cfg_s e;
    logic a, k;
    logic [15:0] q;
    int n;
    {reset_n_i, adapter_present_i, single_cell_i} = '0;
    {otg_request_i, adapter_current_over_i, low_rail_under_i} = '0;
    {battery_discharge_over_i, comparator_above_i} = '0;
    clk_en_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    #1;
    e = '0;
    e.turbo_en = 1'b1;
    e.monitor_en = 1'b1;
    e.converter_switch_en = 1'b1;
    e.cmp_en = 1'b1;
    e.gocp_en = 1'b1;
    chk("cfg reset", cfg_o, e);
    chk("pin reset", {throttle_pin_o, throttle_pin_oe_o,
      throttle_pin_level_o}, 1);
    // First insertion after reset uses the short delay
    @(posedge sys_clk_i);
    adapter_present_i <= 1'b1;
    meas(1, 1'b1, 100, n);
    rng("first insertion", n, 10, 14);
    @(posedge sys_clk_i);
    adapter_present_i <= 1'b0;
    meas(1, 1'b0, 10, n);
    chk("first pending", status_o.first_insert_pending, 0);
    for (int i = 0; i < 2; i++) begin
      wr(CMD_CTRL_B, 16'(i << B_GATE_FAST));
      @(posedge sys_clk_i);
      adapter_present_i <= 1'b1;
      meas(1, 1'b1, 100, n);
      rng("insertion", n, i ? 10 : 40, i ? 14 : 44);
      @(posedge sys_clk_i);
      adapter_present_i <= 1'b0;
      meas(1, 1'b0, 10, n);
    end
    // OTG debounce, both settings, and gate in OTG mode
    for (int i = 0; i < 2; i++) begin
      wr(CMD_CTRL_B, 16'(i << B_OTG_FAST));
      @(posedge sys_clk_i);
      otg_request_i <= 1'b1;
      meas(2, 1'b1, 100, n);
      rng("otg debounce", n, i ? 10 : 40, i ? 14 : 44);
      meas(1, 1'b1, 3, n);
      wr(CMD_CTRL_B, 16'(i << B_OTG_FAST) | 16'h0020);
      meas(1, 1'b0, 3, n);
      @(posedge sys_clk_i);
      otg_request_i <= 1'b0;
    end
    rd(CMD_CTRL_A, 16'h0000);
    HOST.xfer(1'b1, 8'h49, 16'hFFFF, a, k, q);
    chk("unknown code", {a, k}, 32'h0000_0001);
    rd(CMD_CTRL_A, 16'h0000);
    // Frequency override codes
    for (int f = 0; f < 8; f++) begin
      wr(CMD_CTRL_A, 16'(f << A_FREQ_LSB));
      chk("freq", {cfg_o.freq_override, cfg_o.freq_code},
        {f != 0, f[2:0]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(CMD_CTRL_A, 16'(i));
      chk("low rail", cfg_o.low_rail_thr_code, i[2:0]);
    end
    wr(CMD_CTRL_A, 16'h007F);
    rd(CMD_CTRL_A, 16'h007F);
    chk("ctrl a", cfg_o[15:7], 32'h0000_006B);
    @(posedge sys_clk_i);
    adapter_present_i <= 1'b1;
    single_cell_i <= 1'b1;
    #1;
    chk("mon forced", cfg_o.monitor_en, 1);
    chk("single cell", cfg_o.low_rail_thr_code, LOWRAIL_1CELL);
    @(posedge sys_clk_i);
    adapter_present_i <= 1'b0;
    single_cell_i <= 1'b0;
    // Second word decode, all trickle codes
    for (int t = 0; t < 4; t++) begin
      wr(CMD_CTRL_B, 16'(t << B_TRICKLE_LSB) | 16'h101B);
      chk("ctrl b", cfg_o[6:0], {t[1:0], 5'h19});
    end
    rd(CMD_CTRL_B, 16'hD01B);
    // Comparator enable and polarity
    @(posedge sys_clk_i);
    comparator_above_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(CMD_CTRL_B, 16'(4 * i));
      @(posedge sys_clk_i);
      #1;
      chk("comparator", comparator_output_o, i == 0);
    end
    // Throttle debounce per code, held while the source stays
    for (int i = 0; i < 4; i++) begin
      wr(CMD_CTRL_B, 16'(i << B_DEB_LSB) | 16'h01C0);
      @(posedge sys_clk_i);
      if (i[0]) battery_discharge_over_i <= 1'b1;
      else adapter_current_over_i <= 1'b1;
      meas(0, 1'b1, 50, n);
      rng("debounce", n, DEB[i], DEB[i] + 3);
      repeat (12) @(posedge sys_clk_i);
      #1;
      chk("held", {throttle_pin_oe_o, throttle_pin_level_o}, 2);
      chk("source", status_o[4:1], i[0] ? 4'hA : 4'hC);
      @(posedge sys_clk_i);
      {adapter_current_over_i, battery_discharge_over_i} <= 2'b00;
      meas(0, 1'b0, 50, n);
    end
    // Minimum assertion duration per code
    for (int j = 0; j < 8; j++) begin
      wr(CMD_CTRL_B, 16'(j << B_DUR_LSB));
      @(posedge sys_clk_i);
      adapter_current_over_i <= 1'b1;
      meas(0, 1'b1, 50, n);
      @(posedge sys_clk_i);
      adapter_current_over_i <= 1'b0;
      meas(0, 1'b0, 60, n);
      rng("duration", n + 1, DUR[j], DUR[j] + 4);
    end
    // Setting changed mid-interval keeps the running one
    wr(CMD_CTRL_B, 16'h07C0);
    @(posedge sys_clk_i);
    adapter_current_over_i <= 1'b1;
    wr(CMD_CTRL_B, 16'h01C0);
    meas(0, 1'b1, 50, n);
    rng("mid change", n + 2, 9, 13);
    @(posedge sys_clk_i);
    adapter_current_over_i <= 1'b0;
    meas(0, 1'b0, 50, n);
    // Low-rail debounce ignores the longest code
    wr(CMD_CTRL_B, 16'h07C0);
    @(posedge sys_clk_i);
    low_rail_under_i <= 1'b1;
    meas(0, 1'b1, 3000, n);
    rng("low rail deb", n, LOWRAIL_DEB_CYC, LOWRAIL_DEB_CYC + 3);
    chk("low rail src", status_o[3:1], 3'h1);
    @(posedge sys_clk_i);
    low_rail_under_i <= 1'b0;
    meas(0, 1'b0, 50, n);
    // Clock enable low freezes a running debounce
    @(posedge sys_clk_i);
    adapter_current_over_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    chk("frozen", throttle_pin_oe_o, 0);
    meas(0, 1'b1, 50, n);
    rng("enable freeze", n, 6, 7);
    @(posedge sys_clk_i);
    adapter_current_over_i <= 1'b0;
    meas(0, 1'b0, 50, n);
    end_sim();
  end
endmodule
